// [inc/uart_lms_pkg.sv]
`default_nettype none
package uart_lms_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_RX_DATA       = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MODEM_STATUS  = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MODEM_CONTROL = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL       = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS    = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK      = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_RX_SHIFT      = 8'h1c;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int LS_READY    = 0;
  localparam int LS_OVERRUN  = 1;
  localparam int LS_PARITY   = 2;
  localparam int LS_FRAMING  = 3;
  localparam int LS_BREAK    = 4;
  localparam int LS_FIFO_ERR = 7;
  localparam int MC_DTR      = 0;
  localparam int MC_RTS      = 1;
  localparam int MC_OUT1     = 2;
  localparam int MC_OUT2     = 3;
  localparam int MC_LOOP     = 4;
  localparam logic [7:0] MC_WR_MASK = 8'h1f;
  localparam logic [7:0] MC_RESET   = 8'h00;
  localparam int CTRL_FIFO_EN = 0;
  localparam int IRQ_W        = 4;
  localparam int IRQ_MODEM    = 0;
  localparam int IRQ_OVERRUN  = 1;
  localparam int IRQ_RX_ERROR = 2;
  localparam int IRQ_RX_READY = 3;
  localparam int MODEM_W = 4;
  localparam int MDM_CTS = 0;
  localparam int MDM_DSR = 1;
  localparam int MDM_RI  = 2;
  localparam int MDM_CD  = 3;
  localparam logic [MODEM_W-1:0] MODEM_IDLE_N = 4'hf;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       brk;
    logic       framing;
    logic       parity;
    logic [7:0] data;
  } rx_char_t;
  localparam int RX_CHAR_W = $bits(rx_char_t);

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } modem_in_t;

  typedef struct packed {
    logic out2_n;
    logic out1_n;
    logic rts_n;
    logic dtr_n;
  } modem_out_t;

endpackage
`default_nettype wire

// [logic/modem_change_detect.sv]
`default_nettype none
module modem_change_detect
  import uart_lms_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire modem_in_t          pins_n,
  input  wire logic               loopback,
  input  wire logic [MODEM_W-1:0] loop_src,
  input  wire logic               clear,
  output logic      [MODEM_W-1:0] level,
  output logic      [MODEM_W-1:0] change
);

  logic [MODEM_W-1:0] pins_vec;
  logic [MODEM_W-1:0] meta_n;
  logic [MODEM_W-1:0] sync_n;
  logic [MODEM_W-1:0] prev;
  logic [MODEM_W-1:0] event_hit;

  assign pins_vec = pins_n;

  for (genvar i = 0; i < MODEM_W; i++) begin : g_line
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_n[i] <= MODEM_IDLE_N[i];
        sync_n[i] <= MODEM_IDLE_N[i];
        prev[i]   <= 1'b0;
      end else begin
        meta_n[i] <= pins_vec[i];
        sync_n[i] <= meta_n[i];
        prev[i]   <= level[i];
      end
    end
    // Pins are active low, so the reported level is the complement
    assign level[i] = loopback ? loop_src[i] : ~sync_n[i];
    if (i == MDM_RI) begin : g_trail
      // Pin rising 0 to 1 is the reported level falling
      assign event_hit[i] = prev[i] & ~level[i];
    end else begin : g_both
      assign event_hit[i] = prev[i] ^ level[i];
    end
    // A change seen in the cycle of the clearing read survives it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        change[i] <= 1'b0;
      end else if (event_hit[i]) begin
        change[i] <= 1'b1;
      end else if (clear) begin
        change[i] <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [logic/rx_fifo_mem.sv]
`default_nettype none
module rx_fifo_mem
  import uart_lms_pkg::*;
#(
  parameter int WIDTH = RX_CHAR_W,
  parameter int DEPTH = 32
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Write-through keeps the head valid when a push lands on the slot being read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// [logic/uart_line_modem_status.sv]
`default_nettype none
module uart_line_modem_status
  import uart_lms_pkg::*;
#(
  parameter int RX_DEPTH = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_valid,
  input  wire rx_char_t          rx_char,
  input  wire modem_in_t         modem_in_n,
  output modem_out_t             modem_out_n,
  output logic                   irq
);

  // ****************************************
  // Local sizes
  // ****************************************
  localparam int PTR_W = $clog2(RX_DEPTH);
  localparam int CNT_W = $clog2(RX_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);

  logic               setup;
  logic               access;
  logic               rd_access;
  logic               wr_access;
  logic               mapped;
  logic [DATA_W-1:0]  next_prdata;
  logic [7:0]         modem_control;
  logic               fifo_enable;
  logic               loopback;
  logic [IRQ_W-1:0]   irq_status;
  logic [IRQ_W-1:0]   irq_mask;
  logic [IRQ_W-1:0]   irq_events;
  logic               overrun;
  rx_char_t           rx_shift;
  rx_char_t           head_char;
  logic [PTR_W-1:0]   head;
  logic [PTR_W-1:0]   tail;
  logic [PTR_W-1:0]   next_raddr;
  logic [CNT_W-1:0]   count;
  logic [CNT_W-1:0]   err_cnt;
  logic               full;
  logic               flush;
  logic               push;
  logic               pop;
  logic               push_err;
  logic               pop_err;
  logic               overrun_ev;
  logic               ls_read;
  logic               ms_read;
  logic               irq_read;
  logic [7:0]         ls_value;
  logic [7:0]         ms_value;
  logic [MODEM_W-1:0] modem_level;
  logic [MODEM_W-1:0] modem_change;
  logic [MODEM_W-1:0] loop_src;

  // ****************************************
  // APB slave
  // ****************************************
  // Zero wait states: read data is captured in the setup cycle
  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign rd_access = access && !pwrite;
  assign wr_access = access && pwrite && pstrb[0];
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;
  assign ls_read   = rd_access && (paddr == ADDR_LINE_STATUS);
  assign ms_read   = rd_access && (paddr == ADDR_MODEM_STATUS);
  assign irq_read  = rd_access && (paddr == ADDR_IRQ_STATUS);

  always_comb begin
    mapped      = 1'b1;
    next_prdata = '0;
    case (paddr)
      ADDR_RX_DATA:       next_prdata = DATA_W'(head_char.data);
      ADDR_LINE_STATUS:   next_prdata = DATA_W'(ls_value);
      ADDR_MODEM_STATUS:  next_prdata = DATA_W'(ms_value);
      ADDR_MODEM_CONTROL: next_prdata = DATA_W'(modem_control);
      ADDR_CONTROL:       next_prdata = DATA_W'(fifo_enable);
      ADDR_IRQ_STATUS:    next_prdata = DATA_W'(irq_status);
      ADDR_IRQ_MASK:      next_prdata = DATA_W'(irq_mask);
      ADDR_RX_SHIFT:      next_prdata = DATA_W'(rx_shift.data);
      default:            mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_control <= MC_RESET;
      fifo_enable   <= 1'b0;
      irq_mask      <= '0;
    end else if (wr_access) begin
      case (paddr)
        ADDR_MODEM_CONTROL: modem_control <= pwdata[7:0] & MC_WR_MASK;
        ADDR_CONTROL:       fifo_enable   <= pwdata[CTRL_FIFO_EN];
        ADDR_IRQ_MASK:      irq_mask      <= pwdata[IRQ_W-1:0];
        default:            ;
      endcase
    end
  end

  assign loopback = modem_control[MC_LOOP];

  // ****************************************
  // Receive store
  // ****************************************
  // Without FIFO mode the store acts as a single holding register
  assign full  = fifo_enable ? (count == CNT_FULL) : (count != '0);
  assign flush = wr_access && (paddr == ADDR_CONTROL)
              && (pwdata[CTRL_FIFO_EN] != fifo_enable);
  // A full store refuses the character, so stored data is never corrupted
  assign push       = rx_valid && !full && !flush;
  assign overrun_ev = rx_valid && full && !flush;
  assign pop        = rd_access && (paddr == ADDR_RX_DATA) && (count != '0);
  assign push_err   = push && (rx_char.brk || rx_char.framing || rx_char.parity);
  assign pop_err    = pop && (head_char.brk || head_char.framing || head_char.parity);
  assign next_raddr = flush ? '0 : head + PTR_W'(pop);

  rx_fifo_mem #(
    .WIDTH (RX_CHAR_W),
    .DEPTH (RX_DEPTH)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (push),
    .waddr   (tail),
    .wdata   (rx_char),
    .raddr   (next_raddr),
    .rdata   (head_char)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
    end else if (flush) begin
      head  <= '0;
      tail  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        tail <= tail + PTR_W'(1);
      end
      if (pop) begin
        head <= head + PTR_W'(1);
      end
      count <= count + CNT_W'(push) - CNT_W'(pop);
    end
  end

  // Counts stored characters with any error tag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= '0;
    end else if (flush) begin
      err_cnt <= '0;
    end else begin
      err_cnt <= err_cnt + CNT_W'(push_err) - CNT_W'(pop_err);
    end
  end

  // Shift register copy is overwritten by every arrival, also on overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift <= '0;
    end else if (rx_valid) begin
      rx_shift <= rx_char;
    end
  end

  // ****************************************
  // Line status
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (overrun_ev) begin
      overrun <= 1'b1;
    end else if (ls_read) begin
      overrun <= 1'b0;
    end
  end

  always_comb begin
    ls_value = '0;
    ls_value[LS_READY]    = (count != '0);
    ls_value[LS_OVERRUN]  = overrun;
    ls_value[LS_FIFO_ERR] = fifo_enable && (err_cnt != '0);
    if (count != '0) begin
      ls_value[LS_PARITY]  = head_char.parity;
      ls_value[LS_FRAMING] = head_char.framing;
      ls_value[LS_BREAK]   = head_char.brk;
    end
  end

  // ****************************************
  // Modem status
  // ****************************************
  assign loop_src[MDM_CD]  = modem_control[MC_OUT2];
  assign loop_src[MDM_RI]  = modem_control[MC_OUT1];
  assign loop_src[MDM_DSR] = modem_control[MC_DTR];
  assign loop_src[MDM_CTS] = modem_control[MC_RTS];

  modem_change_detect u_modem (
    .pclk     (pclk),
    .presetn  (presetn),
    .pins_n   (modem_in_n),
    .loopback (loopback),
    .loop_src (loop_src),
    .clear    (ms_read),
    .level    (modem_level),
    .change   (modem_change)
  );

  assign ms_value = {modem_level, modem_change};

  // Outputs are held inactive in loop-back; the controls loop inside instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_out_n <= MODEM_IDLE_N;
    end else if (loopback) begin
      modem_out_n <= MODEM_IDLE_N;
    end else begin
      modem_out_n <= ~{modem_control[MC_OUT2], modem_control[MC_OUT1],
                       modem_control[MC_RTS], modem_control[MC_DTR]};
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_MODEM]    = |modem_change;
    irq_events[IRQ_OVERRUN]  = overrun_ev;
    irq_events[IRQ_RX_ERROR] = push_err;
    irq_events[IRQ_RX_READY] = push;
  end

  // New events win over the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_read ? '0 : irq_status) | irq_events;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_push_into_empty;
    push && (count == '0) && !pop && !flush;
  endsequence

  sequence s_err_push_clean;
    push_err && (err_cnt == '0) && fifo_enable;
  endsequence

  a_overrun_flag_set:
    assert property (overrun_ev |=> overrun && ls_value[LS_OVERRUN])
      else $error("overrun not flagged");
  a_overrun_keeps_store:
    assert property (overrun_ev && !pop |=> count == $past(count) && tail == $past(tail))
      else $error("overrun changed stored data");
  a_ready_high:
    assert property (s_push_into_empty |=> ls_value[LS_READY] [*1]
                     ##1 (ls_value[LS_READY] || $past(pop) || $past(flush)))
      else $error("data ready missing");
  a_ready_low:
    assert property (pop && (count == CNT_W'(1)) && !push |=> !ls_value[LS_READY])
      else $error("data ready stuck");
  a_framing_head:
    assert property (s_push_into_empty |=> ls_value[LS_FRAMING] == $past(rx_char.framing))
      else $error("framing flag wrong for head");
  a_parity_head:
    assert property (s_push_into_empty |=> ls_value[LS_PARITY] == $past(rx_char.parity))
      else $error("parity flag wrong for head");
  a_change_latch:
    assert property ($changed(modem_level[MDM_CD]) |=> modem_change[MDM_CD])
      else $error("carrier change not latched");
  a_ring_trailing:
    assert property ($rose(modem_level[MDM_RI]) && !modem_change[MDM_RI]
                     |=> !modem_change[MDM_RI])
      else $error("ring change on wrong edge");
  a_change_clear:
    assert property (ms_read && $stable(modem_level) |=> modem_change == '0)
      else $error("change flags not cleared by read");
  a_loop_mirror:
    assert property (loopback |-> ms_value[7:4] == {modem_control[MC_OUT2],
                     modem_control[MC_OUT1], modem_control[MC_DTR], modem_control[MC_RTS]})
      else $error("loop-back status mismatch");
  a_modem_irq:
    assert property ((|modem_change) && irq_mask[IRQ_MODEM] && !wr_access |=> irq)
      else $error("modem interrupt missing");
  a_fifo_err_set:
    assert property (s_err_push_clean ##1 !flush |-> ls_value[LS_FIFO_ERR])
      else $error("fifo error bit not set");
  a_fifo_err_clear:
    assert property (count == '0 |-> !ls_value[LS_FIFO_ERR])
      else $error("fifo error bit with empty store");

endmodule
`default_nettype wire

// [verification/modem_peer.sv]
`default_nettype none
module modem_peer
  import uart_lms_pkg::*;
(
  input  wire logic       pclk,
  input  wire modem_in_t  want_n,
  input  wire logic [1:0] lag,
  output var  modem_in_t  pins_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Pin drive
  // ****************************************
  // Moves some cycles late, so the synchroniser sees changes at varied offsets
  initial begin
    pins_n = MODEM_IDLE_N;
    forever begin
      @(posedge pclk);
      if (want_n !== pins_n) begin
        repeat (lag) @(posedge pclk);
        pins_n <= want_n;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/uart_line_modem_status_test.sv]
`default_nettype none
module uart_line_modem_status_test import uart_lms_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic              pclk, presetn, psel, penable, pwrite, rx_valid, pready, pslverr, irq, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdat;
  logic [3:0]        pstrb;
  logic [1:0]        lag;
  logic              fifo_on, err_seen;
  rx_char_t          rx_char;
  modem_in_t         modem_in_n, want_n;
  modem_out_t        modem_out_n;
  rx_char_t          q[$];
  int                n_mismatch, total_checks, seed;

  uart_line_modem_status #(.RX_DEPTH(32)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_char(rx_char), .modem_in_n(modem_in_n),
    .modem_out_n(modem_out_n), .irq(irq));

  modem_peer PEER (.pclk(pclk), .want_n(want_n), .lag(lag), .pins_n(modem_in_n));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      n_mismatch++;
    end
  endtask

  task automatic push(input rx_char_t c, input logic keep);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge pclk);
    rx_valid <= 1'b0;
    if (keep) begin
      q.push_back(c);
      err_seen |= c.brk | c.framing | c.parity;
    end
  endtask

  // Expected line status from the bench's own copy of the store
  task automatic ls_chk(input logic ovr);
    logic [7:0] e;
    logic       ferr;
    ferr = 1'b0;
    foreach (q[i]) ferr |= q[i].parity | q[i].framing | q[i].brk;
    e = {6'h00, ovr, 1'b0};
    if (q.size() > 0) e = {ferr & fifo_on, 2'b00, q[0].brk, q[0].framing, q[0].parity, ovr, 1'b1};
    bus(1'b0, ADDR_LINE_STATUS, 8'h00);
    check8("line_status", e, rdat[7:0]);
  endtask

  task automatic drain;
    while (q.size() > 0) begin
      bus(1'b0, ADDR_RX_DATA, 8'h00);
      check8("rx_data", q[0].data, rdat[7:0]);
      void'(q.pop_front());
      ls_chk(1'b0);
    end
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rx_char_t   c;
    logic [3:0] prev, flags, nw, mc;
    logic [1:0] l;
    logic       m;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    rx_valid = 1'b0;
    rx_char = '0;
    fifo_on = 1'b0;
    err_seen = 1'b0;
    want_n = MODEM_IDLE_N;
    lag = 2'h0;
    seed = 31;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check8("modem_out_n", 8'h0f, {4'h0, modem_out_n});
    check8("irq", 8'h00, {7'h00, irq});
    ls_chk(1'b0);
    bus(1'b0, ADDR_MODEM_STATUS, 8'h00);
    check8("modem_status", 8'h00, rdat[7:0]);
    bus(1'b1, ADDR_LINE_STATUS, 8'hff);
    ls_chk(1'b0);
    bus(1'b0, 8'h20, 8'h00);
    check8("pslverr", 8'h01, {7'h00, rerr});
    check8("unmapped", 8'h00, rdat[7:0]);
    bus(1'b1, ADDR_CONTROL, 8'h01);
    fifo_on = 1'b1;
    // Random characters carry random error tags
    repeat (8) push(rx_char_t'(RX_CHAR_W'($random(seed))), 1'b1);
    ls_chk(1'b0);
    drain;
    // Fill to the brim, then one more arrives
    repeat (32) push(rx_char_t'(RX_CHAR_W'($random(seed))), 1'b1);
    c = rx_char_t'(RX_CHAR_W'($random(seed)));
    push(c, 1'b0);
    ls_chk(1'b1);
    bus(1'b0, ADDR_RX_SHIFT, 8'h00);
    check8("rx_shift", c.data, rdat[7:0]);
    drain;
    // Holding register mode: the second arrival overruns the single slot
    bus(1'b1, ADDR_CONTROL, 8'h00);
    fifo_on = 1'b0;
    push(rx_char_t'(RX_CHAR_W'($random(seed))), 1'b1);
    c = rx_char_t'(RX_CHAR_W'($random(seed)));
    push(c, 1'b0);
    ls_chk(1'b1);
    drain;
    // Modem pins: all fall, all rise, then random, with mask toggled
    bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
    check8("irq_status", {4'h0, 1'b1, err_seen, 1'b1, 1'b0}, rdat[7:0]);
    prev = MODEM_IDLE_N;
    flags = 4'h0;
    for (int i = 0; i < 16; i++) begin
      m = (i != 1);
      bus(1'b1, ADDR_IRQ_MASK, {7'h00, m});
      nw = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
      l = 2'($random(seed));
      lag <= l;
      want_n <= nw;
      repeat (l + 7) @(posedge pclk);
      flags |= {prev[3] ^ nw[3], ~prev[2] & nw[2], prev[1:0] ^ nw[1:0]};
      prev = nw;
      check8("irq", {7'h00, m & (flags != 4'h0)}, {7'h00, irq});
      bus(1'b0, ADDR_MODEM_STATUS, 8'h00);
      check8("modem_status", {~nw, flags}, rdat[7:0]);
      bus(1'b0, ADDR_MODEM_STATUS, 8'h00);
      check8("modem_status", {~nw, 4'h0}, rdat[7:0]);
      bus(1'b0, ADDR_IRQ_STATUS, 8'h00);
      check8("irq_status", {7'h00, flags != 4'h0}, rdat[7:0]);
      flags = 4'h0;
      @(negedge pclk);
      check8("irq", 8'h00, {7'h00, irq});
    end
    // Loop-back: status follows the control outputs, pins held idle
    for (int i = 0; i < 6; i++) begin
      mc = 4'($random(seed));
      bus(1'b1, ADDR_MODEM_CONTROL, {4'h0, mc});
      // The output flop follows the control register one edge after the write
      repeat (2) @(negedge pclk);
      check8("modem_out_n", {4'h0, ~mc}, {4'h0, modem_out_n});
      bus(1'b1, ADDR_MODEM_CONTROL, {4'h1, mc});
      repeat (2) @(negedge pclk);
      check8("modem_out_n", 8'h0f, {4'h0, modem_out_n});
      bus(1'b0, ADDR_MODEM_STATUS, 8'h00);
      check8("loop_status", 8'({mc[3:2], mc[0], mc[1]}), 8'(rdat[7:4]));
    end
    test_done;
  end

  // Whole run needs under a thousand cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    test_done;
  end
endmodule
`default_nettype wire
